// [verilog/cache_qos_monitor_regs.sv]
// Overview of operation
// - Monitoring registers exist only when feature bit set; thread select always exists.
// - Per-thread event select: code 7:0, tag 41:32.
// - Per-thread read-only counter, data in 61:0.
// - Bit 62 flags unavailable or unmonitored data.
// - Bit 63 flags unsupported tag or code written.
// - Per-thread association register, tag in 9:0.
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module cache_qos_monitor_regs (
  // Clock and reset
  input  wire logic                                  clk_i,
  input  wire logic                                  rst_i,
  // Wishbone slave
  input  wire logic                                  cyc_i,
  input  wire logic                                  stb_i,
  input  wire logic                                  we_i,
  input  wire logic [qos_monitor_pkg::ADDR_W-1:0]    adr_i,
  input  wire logic [3:0]                            sel_i,
  input  wire logic [31:0]                           dat_i,
  output logic      [31:0]                           dat_o,
  output logic                                       ack_o,
  output logic                                       err_o,
  // Capability and activity from the core
  input  wire logic                                  feature_present_i,
  input  wire logic                                  activity_i,
  input  wire logic [qos_monitor_pkg::THREAD_W-1:0]  activity_thread_i,
  // Tag of each thread for the monitoring fabric
  output logic      [qos_monitor_pkg::TAG_W-1:0]     thread0_tag_o,
  output logic      [qos_monitor_pkg::TAG_W-1:0]     thread1_tag_o
);

  localparam int NT = qos_monitor_pkg::NUM_THREADS;
  localparam int TW = qos_monitor_pkg::TAG_W;
  localparam int CW = qos_monitor_pkg::CODE_W;
  localparam int IW = qos_monitor_pkg::INDEX_W;

  // Monitoring words decode only while the feature is reported.
  function automatic logic monitor_match(input logic          present,
                                         input logic          spare_bit,
                                         input logic [IW-1:0] index,
                                         input logic [IW-1:0] target);
    monitor_match = present & ~spare_bit & (index == target);
  endfunction

  // Per-thread state, then thread select, counter snapshot and read data.
  qos_monitor_pkg::evsel_t          evsel_reg [NT];
  logic [TW-1:0]                    assoc_reg [NT];
  logic [NT-1:0]                    sel_error_reg;
  logic [qos_monitor_pkg::THREAD_W-1:0] thread_reg;
  logic [31:0]                      ctr_hi_snap_reg;
  logic [31:0]                      dat_reg;

  // Decode.
  wire logic [qos_monitor_pkg::INDEX_W-1:0] idx;
  wire logic       upper;
  wire logic       spare;
  wire logic       is_evsel;
  wire logic       is_ctr;
  wire logic       is_assoc;
  wire logic       is_thrsel;
  wire logic       hit;
  wire logic       take;
  wire logic       wr;
  wire logic       rd;

  assign idx   = adr_i[qos_monitor_pkg::INDEX_LSB +: qos_monitor_pkg::INDEX_W];
  assign upper = adr_i[qos_monitor_pkg::HALF_BIT];
  assign spare = adr_i[qos_monitor_pkg::SPARE_BIT];

  // Without the feature the monitoring words answer as unmapped.
  assign is_evsel  = monitor_match(feature_present_i, spare, idx,
                                   qos_monitor_pkg::EVSEL_INDEX);
  assign is_ctr    = monitor_match(feature_present_i, spare, idx,
                                   qos_monitor_pkg::CTR_INDEX);
  assign is_assoc  = monitor_match(feature_present_i, spare, idx,
                                   qos_monitor_pkg::ASSOC_INDEX);
  assign is_thrsel = ~spare & ~upper
                     & (idx == qos_monitor_pkg::THRSEL_INDEX);
  assign hit       = is_evsel | is_ctr | is_assoc | is_thrsel;
  assign wr        = take & hit & we_i;
  assign rd        = take & hit & ~we_i;

  // Current thread's views.
  qos_monitor_pkg::evsel_t cur_evsel;
  wire logic [TW-1:0]       cur_assoc;
  wire logic                cur_error;

  assign cur_evsel = evsel_reg[thread_reg];
  assign cur_assoc = assoc_reg[thread_reg];
  assign cur_error = sel_error_reg[thread_reg];

  // Event select write: merge the bytes, keep only defined fields.
  wire logic [31:0] evsel_lo_old;
  wire logic [31:0] evsel_hi_old;
  wire logic [31:0] evsel_word;
  wire logic [CW-1:0] new_code;
  wire logic [TW-1:0] new_tag;
  wire logic          new_bad;

  assign evsel_lo_old = {24'h0, cur_evsel.code};
  assign evsel_hi_old = {22'h0, cur_evsel.tag};
  assign evsel_word   = qos_monitor_pkg::merge_word(
                          upper ? evsel_hi_old : evsel_lo_old, dat_i, sel_i);
  assign new_code = upper ? cur_evsel.code
                          : evsel_word[qos_monitor_pkg::EVSEL_CODE_LSB +: CW];
  assign new_tag  = upper ? evsel_word[qos_monitor_pkg::EVSEL_TAG_LSB +: TW]
                          : cur_evsel.tag;
  // Error judged on the pair now held after this write.
  assign new_bad  = ~qos_monitor_pkg::tag_supported(new_tag)
                    | (new_code != qos_monitor_pkg::SUPPORTED_CODE);

  // Association write.
  wire logic [31:0] assoc_word;
  wire logic [TW-1:0] new_assoc;
  wire logic          assoc_wr;

  assign assoc_word = qos_monitor_pkg::merge_word({22'h0, cur_assoc},
                                                  dat_i, sel_i);
  assign new_assoc  = assoc_word[qos_monitor_pkg::ASSOC_TAG_LSB +: TW];
  assign assoc_wr   = wr & is_assoc & ~upper;

  // Counter bank.
  wire logic [qos_monitor_pkg::DATA_W-1:0] bank_count;
  wire logic                               bank_monitored;
  wire logic [TW-1:0]                      activity_tag;
  wire logic [TW-1:0]                      query_tag;

  assign activity_tag = assoc_reg[activity_thread_i];
  // The query follows the latest selection of the current thread.
  assign query_tag    = cur_evsel.tag;

  tag_counter_bank counters (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .inc_i       (activity_i),
    .inc_tag_i   (activity_tag),
    .mark_i      (assoc_wr),
    .mark_tag_i  (new_assoc),
    .query_tag_i (query_tag),
    .count_o     (bank_count),
    .monitored_o (bank_monitored)
  );

  // Counter word for the current thread's latest selection.
  qos_monitor_pkg::ctr_word_t ctr_word;
  wire logic                  sel_bad_now;
  wire logic                  no_data;

  assign sel_bad_now = cur_error;
  // A bad selection also has no data, so both flags rise together.
  assign no_data     = sel_bad_now | ~bank_monitored;
  assign ctr_word.error   = sel_bad_now;
  assign ctr_word.unavail = no_data;
  assign ctr_word.data    = no_data ? qos_monitor_pkg::COUNT_RESET
                                    : bank_count;

  // Read multiplexer; reserved bits read as zero.
  wire logic [31:0] thrsel_rd_word;
  wire logic [31:0] evsel_rd_word;
  wire logic [31:0] assoc_rd_word;
  wire logic [31:0] ctr_rd_word;
  wire logic [31:0] rd_word;

  assign thrsel_rd_word = 32'(thread_reg);
  assign evsel_rd_word  = upper ? evsel_hi_old : evsel_lo_old;
  assign assoc_rd_word  = upper ? 32'h0 : {22'h0, cur_assoc};
  // The upper counter word comes from the snapshot, not the live count.
  assign ctr_rd_word    = upper ? ctr_hi_snap_reg
                                : ctr_word[31:0];

  assign rd_word =
      is_thrsel ? thrsel_rd_word
    : is_evsel  ? evsel_rd_word
    : is_assoc  ? assoc_rd_word
    : is_ctr    ? ctr_rd_word
    : 32'h0;

  bus_handshake handshake (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .cyc_i  (cyc_i),
    .stb_i  (stb_i),
    .hit_i  (hit),
    .take_o (take),
    .ack_o  (ack_o),
    .err_o  (err_o)
  );

  // Write strobes for event select and thread select, and the lower counter word read strobe.
  wire logic evsel_wr;
  wire logic thrsel_wr;
  wire logic ctr_lo_rd;

  assign evsel_wr  = wr & is_evsel;
  // The thread number lives in byte lane zero only.
  assign thrsel_wr = wr & is_thrsel & sel_i[0];
  assign ctr_lo_rd = rd & is_ctr & ~upper;

  // Next values; only the selected thread's copy takes a write.
  qos_monitor_pkg::evsel_t evsel_next [NT];
  logic [TW-1:0]           assoc_next [NT];
  logic [NT-1:0]           sel_error_next;

  always_comb begin
    for (int t = 0; t < NT; t++) begin
      evsel_next[t]     = evsel_reg[t];
      sel_error_next[t] = sel_error_reg[t];
      assoc_next[t]     = assoc_reg[t];
      if (thread_reg == qos_monitor_pkg::THREAD_W'(t)) begin
        if (evsel_wr) begin
          evsel_next[t].code = new_code;
          evsel_next[t].tag  = new_tag;
          sel_error_next[t]  = new_bad;
        end
        if (assoc_wr) begin
          assoc_next[t] = new_assoc;
        end
      end
    end
  end

  wire logic [qos_monitor_pkg::THREAD_W-1:0] thread_next;
  wire logic [31:0]                          dat_next;
  wire logic [31:0]                          ctr_hi_snap_next;

  assign thread_next      = thrsel_wr
                            ? dat_i[qos_monitor_pkg::THRSEL_LSB +:
                                    qos_monitor_pkg::THREAD_W]
                            : thread_reg;
  // Read data holds until the next read, so a refused access leaves it.
  assign dat_next         = rd ? rd_word : dat_reg;
  // Reading the lower counter word freezes the upper half to avoid tearing.
  assign ctr_hi_snap_next = ctr_lo_rd
                            ? ctr_word[63:32]
                            : ctr_hi_snap_reg;

  // Event selects and their error flags.
  always_ff @(posedge clk_i) begin
    for (int t = 0; t < NT; t++) begin
      if (rst_i) begin
        evsel_reg[t].code <= qos_monitor_pkg::CODE_RESET;
        evsel_reg[t].tag  <= qos_monitor_pkg::TAG_RESET;
        sel_error_reg[t]  <= 1'b0;
      end else begin
        evsel_reg[t]     <= evsel_next[t];
        sel_error_reg[t] <= sel_error_next[t];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    for (int t = 0; t < NT; t++) begin
      if (rst_i) begin
        assoc_reg[t] <= qos_monitor_pkg::TAG_RESET;
      end else begin
        assoc_reg[t] <= assoc_next[t];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      thread_reg <= '0;
    end else begin
      thread_reg <= thread_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_reg <= 32'h0;
    end else begin
      dat_reg <= dat_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctr_hi_snap_reg <= 32'h0;
    end else begin
      ctr_hi_snap_reg <= ctr_hi_snap_next;
    end
  end

  // Tags handed to the monitoring fabric are registered copies of storage, one cycle behind it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      thread0_tag_o <= qos_monitor_pkg::TAG_RESET;
      thread1_tag_o <= qos_monitor_pkg::TAG_RESET;
    end else begin
      thread0_tag_o <= assoc_reg[0];
      thread1_tag_o <= assoc_reg[1];
    end
  end

  assign dat_o = dat_reg;

endmodule
`default_nettype wire

// [verilog/qos_monitor_pkg.sv]
`default_nettype none
package qos_monitor_pkg;

  // Thread and tag storage sizes.
  localparam int NUM_THREADS = 2;
  localparam int THREAD_W    = 1;
  localparam int CODE_W      = 8;
  localparam int TAG_W       = 10;
  localparam int NUM_TAGS    = 4;
  localparam int DATA_W      = 62;

  // Wishbone geometry; byte address is four times the register index.
  localparam int ADDR_W = 16;
  localparam int INDEX_W = 12;
  localparam int INDEX_LSB = 2;
  localparam int HALF_BIT = 15;
  localparam int SPARE_BIT = 14;

  // Register indices; the upper word of each but thread select sits at index plus the half bit.
  localparam logic [INDEX_W-1:0] EVSEL_INDEX  = 12'hc8d;
  localparam logic [INDEX_W-1:0] CTR_INDEX    = 12'hc8e;
  localparam logic [INDEX_W-1:0] ASSOC_INDEX  = 12'hc8f;
  localparam logic [INDEX_W-1:0] THRSEL_INDEX = 12'hc90;

  // Field positions inside the words.
  localparam int EVSEL_CODE_LSB = 0;
  localparam int EVSEL_TAG_LSB  = 0;
  localparam int ASSOC_TAG_LSB  = 0;
  localparam int THRSEL_LSB     = 0;
  localparam int CTR_UNAVAIL_BIT = 62;
  localparam int CTR_ERROR_BIT   = 63;

  // Reset values and the one event code this bank measures.
  localparam logic [CODE_W-1:0] CODE_RESET     = 8'h00;
  localparam logic [TAG_W-1:0]  TAG_RESET      = 10'h000;
  localparam logic [CODE_W-1:0] SUPPORTED_CODE = 8'h01;
  localparam logic [DATA_W-1:0] COUNT_RESET    = 62'h0;

  typedef struct packed {
    logic [TAG_W-1:0]  tag;
    logic [CODE_W-1:0] code;
  } evsel_t;

  typedef struct packed {
    logic              error;
    logic              unavail;
    logic [DATA_W-1:0] data;
  } ctr_word_t;

  function automatic logic tag_supported(input logic [TAG_W-1:0] tag);
    tag_supported = (tag < TAG_W'(NUM_TAGS));
  endfunction

  function automatic logic [31:0] merge_word(input logic [31:0] old_word,
                                             input logic [31:0] new_word,
                                             input logic [3:0]  sel);
    logic [31:0] mask;
    mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    merge_word = (old_word & ~mask) | (new_word & mask);
  endfunction

endpackage
`default_nettype wire

// [verilog/bus_handshake.sv]
`timescale 1ns/1ns
`default_nettype none
module bus_handshake (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Request
  input  wire logic cyc_i,
  input  wire logic stb_i,
  input  wire logic hit_i,
  // Answer
  output logic      take_o,
  output logic      ack_o,
  output logic      err_o
);

  logic ack_reg;
  logic err_reg;
  logic busy;

  // A request is taken once; the answer cycle itself blocks a second take.
  assign busy   = ack_reg | err_reg;
  assign take_o = cyc_i & stb_i & ~busy;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      ack_reg <= take_o & hit_i;
      err_reg <= take_o & ~hit_i;
    end
  end

  assign ack_o = ack_reg;
  assign err_o = err_reg;

endmodule
`default_nettype wire

// [verilog/tag_counter_bank.sv]
`timescale 1ns/1ns
`default_nettype none
module tag_counter_bank (
  // Clock and reset
  input  wire logic                                clk_i,
  input  wire logic                                rst_i,
  // Counting
  input  wire logic                                inc_i,
  input  wire logic [qos_monitor_pkg::TAG_W-1:0]   inc_tag_i,
  // Tag becomes monitored
  input  wire logic                                mark_i,
  input  wire logic [qos_monitor_pkg::TAG_W-1:0]   mark_tag_i,
  // Query
  input  wire logic [qos_monitor_pkg::TAG_W-1:0]   query_tag_i,
  output logic      [qos_monitor_pkg::DATA_W-1:0]  count_o,
  output logic                                     monitored_o
);

  localparam int N = qos_monitor_pkg::NUM_TAGS;

  logic [qos_monitor_pkg::DATA_W-1:0] count_reg [N];
  logic [N-1:0]                       monitored_reg;
  logic                               query_ok;

  // Only tags that have storage are counted; others never count.
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < N; i++) begin
      if (rst_i) begin
        count_reg[i] <= qos_monitor_pkg::COUNT_RESET;
        monitored_reg[i] <= 1'b0;
      end else begin
        if (inc_i && monitored_reg[i]
            && inc_tag_i == qos_monitor_pkg::TAG_W'(i)) begin
          count_reg[i] <= count_reg[i] + 62'h1;
        end
        if (mark_i && mark_tag_i == qos_monitor_pkg::TAG_W'(i)) begin
          monitored_reg[i] <= 1'b1;
        end
      end
    end
  end

  assign query_ok    = qos_monitor_pkg::tag_supported(query_tag_i);
  assign count_o     = query_ok ? count_reg[query_tag_i[1:0]]
                                : qos_monitor_pkg::COUNT_RESET;
  assign monitored_o = query_ok & monitored_reg[query_tag_i[1:0]];

endmodule
`default_nettype wire

// [bench/cache_qos_monitor_regs_assertions.sv]
`timescale 1ns/1ns
`default_nettype none
module cache_qos_monitor_regs_assertions (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [15:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        err_o,
  input wire logic        feature_present_i,
  input wire logic [9:0]  thread0_tag_o,
  input wire logic [9:0]  thread1_tag_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire take = cyc_i & stb_i & ~ack_o & ~err_o;
  wire rd = ack_o & ~we_i;
  property p_answer; take |=> ack_o ^ err_o; endproperty
  a_answer: assert property (p_answer) else $error("no single answer");
  property p_one; ack_o | err_o |=> !ack_o && !err_o; endproperty
  a_one: assert property (p_one) else $error("answer too long");
  property p_feat;
    take && !feature_present_i && adr_i[13:2] inside {12'hc8d, 12'hc8e,
      12'hc8f} |=> err_o;
  endproperty
  a_feat: assert property (p_feat) else $error("absent reg answered");
  property p_evsel;
    rd && adr_i[14:0] == 15'h3234 |-> (dat_o >> (adr_i[15] ? 10 : 8)) == 0;
  endproperty
  a_evsel: assert property (p_evsel) else $error("select spare bits");
  property p_error;
    rd && adr_i == 16'hb238 && dat_o[31] |-> dat_o[30:0] == 31'h40000000;
  endproperty
  a_error: assert property (p_error) else $error("error word wrong");
  property p_assoc; rd && adr_i == 16'hb23c |-> dat_o == 32'h0; endproperty
  a_assoc: assert property (p_assoc) else $error("assoc high nonzero");
  property p_tag;
    $changed({thread1_tag_o, thread0_tag_o}) |->
      $past(ack_o && we_i && adr_i == 16'h323c);
  endproperty
  a_tag: assert property (p_tag) else $error("tag moved alone");
  property p_dat; $changed(dat_o) |-> ack_o; endproperty
  a_dat: assert property (p_dat) else $error("read data moved");
  property p_errdat; err_o |-> $stable(dat_o); endproperty
  a_errdat: assert property (p_errdat) else $error("refused read data");
  c_wr: cover property (take && we_i);
  c_err: cover property (err_o);
  c_flag: cover property (rd && adr_i == 16'hb238 && dat_o[31]);
endmodule
`default_nettype wire

// [bench/cache_qos_monitor_regs_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module cache_qos_monitor_regs_tb;
  logic        clk_i = 0;
  logic        rst_i = 1;
  logic        cyc_i = 0;
  logic        stb_i = 0;
  logic        we_i = 0;
  logic [15:0] adr_i = 16'h0;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic        feature_present_i = 0;
  logic        activity_i = 0;
  logic        activity_thread_i = 0;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        err_o;
  logic [9:0]  thread0_tag_o;
  logic [9:0]  thread1_tag_o;
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          c1 = 0;
  int          c3 = 0;
  logic [15:0] rnd = 16'hd787;
  logic [33:0] notes[$];
  logic [33:0] nt;
  logic [7:0]  cd[4] = '{8'h02, 8'h01, 8'h01, 8'h00};
  logic [9:0]  tg[4] = '{10'h1, 10'h4, 10'h3, 10'h1};
  logic        xe[4] = '{1'b1, 1'b1, 1'b0, 1'b1};
  cache_qos_monitor_regs u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
    .feature_present_i(feature_present_i), .activity_i(activity_i),
    .activity_thread_i(activity_thread_i),
    .thread0_tag_o(thread0_tag_o), .thread1_tag_o(thread1_tag_o));
  initial forever #2 clk_i = ~clk_i;
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic print_verdict;
    $display("Counts: %0d compared, %0d mismatched", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic cmp_data(input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic cmp_kind(input logic e, input logic g);
    cmp_data({31'h0, e}, {31'h0, g});
  endtask
  // The note says whether to skip data, whether err is due, and read data.
  task automatic xfer(input logic w, input logic [15:0] a,
                      input logic [31:0] d, input logic [3:0] s,
                      input logic [33:0] n);
    int i;
    @(posedge clk_i);
    notes.push_back(n);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    for (i = 0; i < 20 && !(ack_o | err_o); i++) @(posedge clk_i);
    if (i == 20) begin
      n_mismatch++;
      print_verdict();
    end
    cyc_i <= 0;
    stb_i <= 0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    xfer(1, a, d, s, {2'b10, 32'h0});
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] x);
    xfer(0, a, 32'h0, 4'hf, {2'b00, x});
  endtask
  task automatic bad(input logic [15:0] a);
    xfer(0, a, 32'h0, 4'hf, {2'b11, 32'h0});
  endtask
  task automatic pulse(input logic t);
    @(posedge clk_i);
    activity_i <= 1;
    activity_thread_i <= t;
    @(posedge clk_i);
    activity_i <= 0;
  endtask
  always @(posedge clk_i) begin
    if (!rst_i && (ack_o | err_o)) begin
      nt = notes.pop_front();
      cmp_kind(nt[32], err_o);
      if (!nt[33]) begin
        cmp_data(nt[31:0], dat_o);
      end
    end
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    bad(16'h3234);
    bad(16'h3238);
    feature_present_i <= 1;
    $display("feature gate done");
    wr(16'h3234, {rnd, 16'h0001}, 4'hf);
    rd(16'h3234, 32'h1);
    wr(16'h3234, 32'hff, 4'h2);
    rd(16'h3234, 32'h1);
    wr(16'hb234, {rnd, 16'h0001}, 4'hf);
    rd(16'hb234, 32'h1);
    wr(16'h323c, 32'hfffffc01, 4'hf);
    rd(16'h323c, 32'h1);
    rd(16'hb23c, 32'h0);
    wr(16'h3240, 32'h1, 4'hf);
    wr(16'h323c, 32'h3, 4'hf);
    wr(16'h3234, 32'h1, 4'hf);
    wr(16'hb234, 32'h3, 4'hf);
    rd(16'h323c, 32'h3);
    cmp_data(32'h1, {22'h0, thread0_tag_o});
    cmp_data(32'h3, {22'h0, thread1_tag_o});
    $display("select and tag done");
    for (int n = 0; n < 12; n++) begin
      rnd = lfsr(rnd);
      pulse(rnd[0]);
      if (rnd[0]) c3++; else c1++;
    end
    rd(16'h3238, c3);
    rd(16'hb238, 32'h0);
    wr(16'h3238, 32'hffffffff, 4'hf);
    rd(16'h3238, c3);
    wr(16'h3240, 32'h0, 4'hf);
    rd(16'h3238, c1);
    wr(16'hb234, 32'h2, 4'hf);
    rd(16'h3238, 32'h0);
    rd(16'hb238, 32'h40000000);
    $display("counter done");
    for (int n = 0; n < 4; n++) begin
      wr(16'h3234, {24'h0, cd[n]}, 4'hf);
      wr(16'hb234, {22'h0, tg[n]}, 4'hf);
      rd(16'h3238, xe[n] ? 32'h0 : c3);
      rd(16'hb238, xe[n] ? 32'hc0000000 : 32'h0);
    end
    bad(16'h3244);
    bad(16'h7234);
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    rd(16'h3234, 32'h0);
    $display("error and reset done");
    print_verdict();
  end
endmodule
bind cache_qos_monitor_regs cache_qos_monitor_regs_assertions u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
  .err_o(err_o), .feature_present_i(feature_present_i),
  .thread0_tag_o(thread0_tag_o), .thread1_tag_o(thread1_tag_o));
`default_nettype wire
